// ---- rtl/ascp_pkg.sv ----
// package of constants for the serial command port of the acquisition device
package ascp_pkg;
  localparam int CFG_BITS    = 7;
  localparam int RES_BITS    = 12;
  localparam int CFG_SINGLE  = 6;
  localparam int CFG_ODD     = 5;
  localparam int CFG_SEL1    = 4;
  localparam int CFG_SEL0    = 3;
  localparam int CFG_POL     = 2;
  localparam int CFG_ORDER   = 1;
  localparam int CFG_PWR     = 0;
  localparam logic [1:0] SEL_UNUSED = 2'h3;
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [6:0] CFG_RESET  = 7'h00;
  localparam logic [11:0] RES_ONES  = 12'hfff;
  localparam logic [11:0] RES_RESET = 12'h000;
  localparam logic SCLK_RESET       = 1'b0;
  localparam logic SDO_RESET        = 1'b0;
  localparam logic OE_RESET         = 1'b0;
  localparam logic OFF_N_RESET      = 1'b1;
  localparam logic START_RESET      = 1'b0;
  typedef enum logic [2:0] {
    ASCP_IDLE, ASCP_HUNT, ASCP_CFG, ASCP_NULL, ASCP_MSB, ASCP_LSB, ASCP_FILL
  } ascp_state_e;
endpackage

// ---- rtl/ascp_port.sv ----
// serial command and result port of the acquisition device
`timescale 1ns/10ps
// Overview of operation
// - launch on falling clock, sample on rising
// - chip select low starts start bit hunt
// - first sampled one is start bit
// - capture seven config bits, launch conversion if power bit is one
// - ignore input after config until reselect
// - null bit, then current conversion result
// - input and output phases never overlap
// - chip select high returns port idle
// - address order: single flag, odd, sel1, sel0
// - single ended channel is 2*sel+odd
// - pair mode: odd bit picks positive channel
// - six channel variant leaves select 11 unused
// - polarity one unipolar, zero bipolar
// - order flag: msb then zeros, else lsb copy
// - power down: shutdown, ones word, zeros
// - system off output low until reselect
// - chip select high floats serial output
module ascp_port #(
  parameter int CHANNELS = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  output logic                       sdo,
  output logic                       sdo_oe,
  output logic                       system_off_n,
  output logic                       conv_start,
  output logic [2:0]                 pos_channel,
  output logic [2:0]                 neg_channel,
  output logic                       neg_is_shared_return,
  output logic                       polarity_mode_bit,
  output logic                       channel_valid,
  input  wire logic [ascp_pkg::RES_BITS-1:0] conv_result
);
  import ascp_pkg::*;

  // only the six- and eight-input select decodes exist
  if (CHANNELS != 8 && CHANNELS != 6) begin
    $error("ascp_port: CHANNELS must be 6 or 8");
  end

  ascp_state_e state_q, state_d;
  logic              sclk_q;
  logic [6:0]        cfg_q, cfg_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [11:0]       res_q, res_d;
  logic              sdo_q, sdo_d;
  logic              oe_q, oe_d;
  logic              off_n_q, off_n_d;
  logic              start_q, start_d;

  wire rise = sclk & ~sclk_q;
  wire fall = ~sclk & sclk_q;
  wire [6:0] cfg_next = {cfg_q[5:0], sdi};
  wire last_cfg = (cnt_q == 4'(CFG_BITS - 1));
  wire last_res = (cnt_q == 4'(RES_BITS - 1));
  wire bit_order_flag      = cfg_q[CFG_ORDER];
  wire power_down_n_bit    = cfg_q[CFG_PWR];
  wire [1:0] sel = {cfg_q[CFG_SEL1], cfg_q[CFG_SEL0]};
  wire single_vs_pair_flag = cfg_q[CFG_SINGLE];
  wire odd = cfg_q[CFG_ODD];
  // msb-only order and shutdown both pad with zeros after the first word
  wire fill_after_msb = bit_order_flag || !power_down_n_bit;
  // pair mode: odd flag chooses which member of the pair is positive
  wire [2:0] even_ch   = {sel, 1'b0};
  wire [2:0] odd_ch    = {sel, 1'b1};
  wire [2:0] single_ch = {sel, odd};
  wire [2:0] pair_pos  = odd ? odd_ch : even_ch;
  wire [2:0] pair_neg  = odd ? even_ch : odd_ch;

  assign pos_channel = single_vs_pair_flag ? single_ch : pair_pos;
  assign neg_channel = single_vs_pair_flag ? 3'h0 : pair_neg;
  assign neg_is_shared_return = single_vs_pair_flag;
  assign polarity_mode_bit = cfg_q[CFG_POL];
  assign channel_valid = !(CHANNELS == 6 && sel == SEL_UNUSED);
  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign system_off_n = off_n_q;
  assign conv_start = start_q;

  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    res_d = res_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    off_n_d = off_n_q;
    start_d = 1'b0;
    if (cs_n) begin
      // idle: output floats, but shutdown persists until the next select
      state_d = ASCP_IDLE;
      oe_d = 1'b0;
      sdo_d = 1'b0;
    end else begin
      unique case (state_q)
        ASCP_IDLE: begin
          state_d = ASCP_HUNT;
          off_n_d = 1'b1;
          cnt_d = CNT_ZERO;
        end
        ASCP_HUNT: begin
          if (rise && sdi) begin
            state_d = ASCP_CFG;
            cnt_d = CNT_ZERO;
          end
        end
        ASCP_CFG: begin
          if (rise) begin
            cfg_d = cfg_next;
            cnt_d = cnt_q + 4'h1;
            if (last_cfg) begin
              state_d = ASCP_NULL;
              start_d = cfg_next[CFG_PWR];
              off_n_d = cfg_next[CFG_PWR];
              res_d = cfg_next[CFG_PWR] ? conv_result : RES_ONES;
            end
          end
        end
        ASCP_NULL: begin
          // output only turns on after the last input bit: half duplex
          if (fall) begin
            oe_d = 1'b1;
            sdo_d = 1'b0;
            state_d = ASCP_MSB;
            cnt_d = CNT_ZERO;
          end
        end
        ASCP_MSB: begin
          if (fall) begin
            sdo_d = res_q[RES_BITS - 1 - cnt_q];
            cnt_d = cnt_q + 4'h1;
            if (last_res) begin
              state_d = fill_after_msb ? ASCP_FILL : ASCP_LSB;
              cnt_d = 4'h1;  // lsb is shared by both copies
            end
          end
        end
        ASCP_LSB: begin
          if (fall) begin
            sdo_d = res_q[cnt_q];
            cnt_d = cnt_q + 4'h1;
            if (last_res)
              state_d = ASCP_FILL;
          end
        end
        ASCP_FILL: begin
          if (fall)
            sdo_d = 1'b0;
        end
        default: state_d = ASCP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ASCP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // serial clock history for edge detection; harmless while deselected
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_q <= SCLK_RESET;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // result is frozen when the command completes, so a late input change
  // cannot leak into the word being shifted out
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res_q <= RES_RESET;
    end else begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdo_q <= SDO_RESET;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_q <= OE_RESET;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      off_n_q <= OFF_N_RESET;
    end else begin
      off_n_q <= off_n_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_q <= START_RESET;
    end else begin
      start_q <= start_d;
    end
  end
endmodule

// ---- sim/ascp_port_chk.sv ----
// assertions on the serial command port pins
`timescale 1ns/10ps
module ascp_port_chk (
  input logic mclk,
  input logic rst,
  input logic cs_n,
  input logic sclk,
  input logic sdo,
  input logic sdo_oe,
  input logic system_off_n,
  input logic conv_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_idle_float: assert property (
    cs_n |=> !sdo_oe) else $error("output on while idle");
  chk_oe_on_fall: assert property (
    $rose(sdo_oe) |-> !sclk && !cs_n) else $error("oe rose off fall");
  chk_null_first: assert property (
    $rose(sdo_oe) |-> !sdo) else $error("null bit not low");
  chk_sdo_launch: assert property (
    sdo_oe && $changed(sdo) |-> !sclk) else $error("sdo moved on high");
  chk_conv_rise: assert property (
    conv_start |-> $past(sclk) && !$past(sclk, 2) && !$past(cs_n))
    else $error("start off rise");
  chk_off_rise: assert property (
    $fell(system_off_n) |-> $past(sclk) && !$past(sclk, 2))
    else $error("off not on rise");
  chk_off_hold: assert property (
    !system_off_n && cs_n |=> !system_off_n) else $error("off lost");
  chk_cmd_float: assert property (
    $fell(cs_n) |-> !sdo_oe [*8]) else $error("oe during command");
  chk_start_pulse: assert property (
    conv_start |=> !conv_start) else $error("start held high");
endmodule
bind ascp_port ascp_port_chk u_chk (.mclk, .rst, .cs_n, .sclk, .sdo,
  .sdo_oe, .system_off_n, .conv_start);

// ---- sim/ascp_host.sv ----
// host controller model for the serial command port
`timescale 1ns/10ps
module ascp_host (
  input  logic mclk,
  input  logic sdo,
  input  logic sdo_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // launch on the fall, sample on the rise
  task automatic bitc(input logic d, output logic q);
    sclk = 1'b0;
    sdi = d;
    repeat (2) @(negedge mclk);
    q = sdo_oe ? sdo : 1'bx;
    sclk = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic xfer(input int ld, input logic [6:0] c,
                      output logic [24:0] rx);
    logic q;
    @(negedge mclk);
    cs_n = 1'b0;
    repeat (2) @(negedge mclk);
    repeat (ld) bitc(1'b0, q);
    bitc(1'b1, q);
    for (int i = 6; i >= 0; i--) bitc(c[i], q);
    // line released: toggle so a stale level cannot pass
    for (int i = 24; i >= 0; i--) begin
      bitc(~sdi, q);
      rx[i] = q;
    end
  endtask
  // open an exchange and leave it hanging n bits after the start bit
  task automatic part(input int n);
    logic q;
    @(negedge mclk);
    cs_n = 1'b0;
    repeat (2) @(negedge mclk);
    bitc(1'b1, q);
    repeat (n) bitc(1'b1, q);
  endtask
  task automatic stop;
    cs_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the serial command port
`timescale 1ns/10ps
module testbench;
  import ascp_pkg::*;
  logic mclk, rst, cs_n, sclk, sdi, sdo, sdo_oe, system_off_n, conv_start;
  logic [2:0] pos_channel, neg_channel;
  logic neg_is_shared_return, polarity_mode_bit, channel_valid, valid_six;
  logic [11:0] conv_result = 12'h000;
  logic [24:0] rx;
  logic [8:0] mux_exp;
  int fails = 0, total_checks = 0, starts = 0, n0 = 0;
  wire [8:0] mux_word = {pos_channel, neg_channel, neg_is_shared_return,
    polarity_mode_bit, channel_valid};
  // command, result, expected positive and negative channel
  logic [24:0] rows [5] = '{{7'h5f, 12'ha5c, 6'h30}, {7'h6d, 12'h7ff, 6'h18},
    {7'h31, 12'h800, 6'h2c}, {7'h03, 12'h001, 6'h01},
    {7'h46, 12'h123, 6'h00}};
  ascp_port dut (.mclk, .rst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe,
    .system_off_n, .conv_start, .pos_channel, .neg_channel,
    .neg_is_shared_return, .polarity_mode_bit, .channel_valid,
    .conv_result);
  ascp_host host (.mclk, .sdo, .sdo_oe, .cs_n, .sclk, .sdi);
  // six-input build on the same pins: only its select decode differs
  ascp_port #(.CHANNELS(6)) dut_six (.mclk, .rst, .cs_n, .sclk, .sdi,
    .sdo(), .sdo_oe(), .system_off_n(), .conv_start(), .pos_channel(),
    .neg_channel(), .neg_is_shared_return(), .polarity_mode_bit(),
    .channel_valid(valid_six), .conv_result);
  // a start pulse stands one full clock, so each falling edge sees it once
  always @(negedge mclk) begin
    if (conv_start === 1'b1)
      starts++;
  end
  function automatic logic [24:0] exp_rx(logic [6:0] c, logic [11:0] r);
    logic [24:0] e;
    e = {1'b0, r, 12'h000};
    if (!c[CFG_PWR]) e = {1'b0, RES_ONES, 12'h000};
    else if (!c[CFG_ORDER])
      for (int i = 1; i < 12; i++) e[12 - i] = r[i];
    return e;
  endfunction
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #300us;
    fails++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    chk({sdo_oe, system_off_n, conv_start}, 25'h2);
    foreach (rows[k]) begin
      conv_result = rows[k][17:6];
      mux_exp = {rows[k][5:0], rows[k][24], rows[k][20], 1'b1};
      n0 = starts;
      host.xfer(k % 3, rows[k][24:18], rx);
      chk(rx, exp_rx(rows[k][24:18], rows[k][17:6]));
      chk(mux_word, mux_exp);
      chk(valid_six, rows[k][22:21] != SEL_UNUSED);
      chk(25'(starts - n0), rows[k][18]);
      host.stop;
      chk(sdo_oe, 1'b0);
    end
    chk(system_off_n, 1'b0);
    // back-to-back exchange must carry the fresh result only
    conv_result = 12'h3c3;
    host.xfer(0, 7'h5f, rx);
    chk(rx, {1'b0, 12'h3c3, 12'h000});
    chk(system_off_n, 1'b1);
    host.stop;
    // frame cut inside the command: the next exchange must start clean
    host.part(3);
    host.stop;
    host.xfer(1, 7'h44, rx);
    chk(rx, exp_rx(7'h44, 12'h3c3));
    host.stop;
    // reset in mid-result: the output must float at once
    host.part(9);
    chk(sdo_oe, 1'b1);
    rst = 1'b1;
    @(negedge mclk);
    chk({sdo_oe, system_off_n, conv_start}, 25'h2);
    rst = 1'b0;
    host.stop;
    conv_result = 12'h5a5;
    host.xfer(2, 7'h5f, rx);
    chk(rx, {1'b0, 12'h5a5, 12'h000});
    host.stop;
    complete_run;
  end
endmodule
